// >>> arf_pkg.sv
// Purpose: shared constants and types of the converter result FIFO and host port
// Assumes: 12-bit results, two 10-bit control registers
// Notes: bit positions are those of the two control registers
package arf_pkg;

  localparam int DATA_W = 12;
  localparam int REG_W = 10;
  localparam int PTR_W = 4;
  localparam int LVL_W = 5;
  localparam int FIFO_DEPTH = 16;
  localparam int PIPE_LAT = 7;
  localparam int PIN_W = 17;

  localparam logic [LVL_W-1:0] LVL_FULL = 5'h10;
  localparam logic [LVL_W-1:0] LVL_ONE = 5'h01;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;

  // register address carried on data lines 11:10
  localparam int ADDR_HI = 11;
  localparam int ADDR_LO = 10;
  localparam logic [1:0] ADDR_CONV_CFG = 2'h0;
  localparam logic [1:0] ADDR_FIFO_CFG = 2'h1;

  localparam logic [REG_W-1:0] CONV_CFG_RST = 10'h020;
  localparam logic [REG_W-1:0] FIFO_CFG_RST = 10'h000;
  // action bits of fifo_output_config that do not stay set
  localparam logic [REG_W-1:0] FIFO_CFG_SELF_CLR = 10'h003;

  // conversion_config fields
  localparam int CC_TEST_HI = 9;
  localparam int CC_TEST_LO = 8;
  localparam int CC_AUTOSCAN = 7;
  localparam int CC_BAL_HI = 6;
  localparam int CC_BAL_LO = 5;
  localparam int CC_CHAN_HI = 4;
  localparam int CC_CHAN_LO = 3;
  localparam int CC_PWRDN = 2;
  localparam int CC_MODE = 1;
  localparam int CC_REF_SEL = 0;

  // fifo_output_config fields
  localparam int FC_READBACK = 9;
  localparam int FC_OFFSET = 8;
  localparam int FC_FORMAT = 7;
  localparam int FC_RW_CFG = 6;
  localparam int FC_RDY_POL = 5;
  localparam int FC_RDY_TYPE = 4;
  localparam int FC_TRIG_HI = 3;
  localparam int FC_TRIG_LO = 2;
  localparam int FC_OVF_FRST = 1;
  localparam int FC_SOFT_RST = 0;

  // trigger levels, one and two channels
  localparam logic [LVL_W-1:0] TL_1CH_0 = 5'h01;
  localparam logic [LVL_W-1:0] TL_1CH_1 = 5'h04;
  localparam logic [LVL_W-1:0] TL_1CH_2 = 5'h08;
  localparam logic [LVL_W-1:0] TL_1CH_3 = 5'h0e;
  localparam logic [LVL_W-1:0] TL_2CH_0 = 5'h02;
  localparam logic [LVL_W-1:0] TL_2CH_1 = 5'h04;
  localparam logic [LVL_W-1:0] TL_2CH_2 = 5'h08;
  localparam logic [LVL_W-1:0] TL_2CH_3 = 5'h0c;

  localparam int SIGN_BIT = 11;

  // pin vector layout after synchronisation
  localparam int PIN_CCLK = 16;
  localparam int PIN_CSL_N = 15;
  localparam int PIN_CSH = 14;
  localparam int PIN_RD_N = 13;
  localparam int PIN_WR_N = 12;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_CH_A = 3'b010,
    SEQ_CH_B = 3'b100
  } arf_seq_t;

endpackage : arf_pkg

// >>> arf_word_if.sv
// Purpose: valid/ready word carrier between the sequencer, buffer and FIFO
// Assumes: single clock domain
// Notes: source drives valid and data, sink drives ready
`timescale 1ns/1ps
`default_nettype none
interface arf_word_if;
  logic valid;
  logic ready;
  logic [11:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : arf_word_if
`default_nettype wire

// >>> arf_word_buf.sv
// Purpose: two-entry buffer so a stalled FIFO loses no word
// Assumes: clear empties it in one cycle
// Notes: ready on the filling side drops only when both entries hold data
`timescale 1ns/1ps
`default_nettype none
module arf_word_buf (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic clear_i,
  // words in and out
  arf_word_if.snk in_w,
  arf_word_if.src out_w
);

  logic [11:0] mem [2];
  logic wr_idx;
  logic rd_idx;
  logic [1:0] count;
  logic push;
  logic pop;

  assign push = in_w.valid & in_w.ready;
  assign pop = out_w.valid & out_w.ready;
  assign in_w.ready = (count != 2'h2);
  assign out_w.valid = (count != 2'h0);
  assign out_w.data = mem[rd_idx];

  always_ff @(posedge clk_i)
  begin
    if (clk_en_i && push)
    begin
      mem[wr_idx] <= in_w.data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
      count <= 2'h0;
    end
    else if (clk_en_i)
    begin
      if (clear_i)
      begin
        wr_idx <= 1'b0;
        rd_idx <= 1'b0;
        count <= 2'h0;
      end
      else
      begin
        if (push)
        begin
          wr_idx <= ~wr_idx;
        end
        if (pop)
        begin
          rd_idx <= ~rd_idx;
        end
        count <= count + {1'b0, push} - {1'b0, pop};
      end
    end
  end

  a_buf_count_bound: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    count <= 2'h2) else $error("buffer holds more than two words");

  a_buf_keeps_word: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && push && !pop && !clear_i) |=> (count == $past(count) + 2'h1))
    else $error("buffered word was lost");

endmodule : arf_word_buf
`default_nettype wire

// >>> arf_host_port.sv
// Purpose: result formatting, 16-word circular FIFO, trigger pulse and host port
// Assumes: analog core hands offset binary codes on the core clock; pins are asynchronous
// Notes: all pin inputs pass two flip-flops; outputs are registered
`timescale 1ns/1ps
`default_nettype none
// Contract
// - single-ended binary: top FFF, middle 800, bottom 000
// - single-ended twos complement: top 7FF, middle 000, bottom 800
// - differential binary: +span FFF, zero 800, -span 000
// - differential twos complement: +span 7FF, zero 000, -span 800
// - circular buffer holds at most 16 results
// - every finished conversion enters the buffer without host help
// - read pointer names the next word to read and advances per read
// - write pointer names the entry holding the newest sample
// - multi-channel results are stored in fixed channel order
// - data_ready_n fires when new stored count reaches trigger level
// - data_ready_n is a low pulse, not a level
// - each block starts with the first autoscan channel
// - one input: trigger levels 1, 4, 8 or 14; set depends on channels
// - read needs chip_select_low low, chip_select_high high, read strobe low
// - two 10-bit control registers set the operating mode
// - conversion_config field layout, bit 9 down to bit 0
// - fifo_output_config field layout, bit 9 down to bit 0
// - write data on lines 0 to 9, address on lines 10 and 11
// - address 00 selects first register, 01 second, others reserved
// - first pulse after buffer reset comes 7 plus trigger_count conversions late; in single mode the code pulses after trigger_count conversions
// - in single mode each conversion_clock falling edge starts a conversion
module arf_host_port (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // converter core results
  input wire logic [11:0] sample_a_i,
  input wire logic [11:0] sample_b_i,
  // host pins
  input wire logic conversion_clock_i,
  input wire logic chip_select_low_n_i,
  input wire logic chip_select_high_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic [11:0] data_i,
  output logic [11:0] data_o,
  output logic data_oe_o,
  output logic data_ready_n_o,
  // analog core controls
  output logic powerdown_o,
  output logic ref_select_o,
  output logic [1:0] test_sel_o
);

  logic [arf_pkg::PIN_W-1:0] pin_raw;
  logic [arf_pkg::PIN_W-1:0] pin_s1;
  logic [arf_pkg::PIN_W-1:0] pin_s2;
  logic [arf_pkg::PIN_W-1:0] pin_q;
  logic rd_act;
  logic rd_act_q;
  logic rd_start;
  logic wr_act;
  logic wr_act_q;
  logic wr_start;
  logic cclk_fall;
  logic [arf_pkg::REG_W-1:0] conversion_config;
  logic [arf_pkg::REG_W-1:0] fifo_output_config;
  logic fifo_clear;
  logic soft_rst;
  logic overflow;
  logic two_ch;
  logic [arf_pkg::LVL_W-1:0] trig_lvl;
  logic pipe_adv;
  logic conv_start;
  logic [arf_pkg::PIPE_LAT-1:0] pipe_v;
  logic [11:0] pipe_a [arf_pkg::PIPE_LAT];
  logic [11:0] pipe_b [arf_pkg::PIPE_LAT];
  logic pipe_out;
  arf_pkg::arf_seq_t seq;
  logic [11:0] hold_a;
  logic [11:0] hold_b;
  logic hold_two;
  logic [11:0] cur_code;
  logic drop;
  logic [11:0] fifo_mem [arf_pkg::FIFO_DEPTH];
  logic [arf_pkg::PTR_W-1:0] rd_ptr;
  logic [arf_pkg::PTR_W-1:0] wr_last;
  logic [arf_pkg::LVL_W-1:0] level;
  logic [arf_pkg::LVL_W-1:0] new_cnt;
  logic store;
  logic take;
  logic rb_sel;

  arf_word_if seq_w ();
  arf_word_if fifo_w ();

  // trigger level decode by channel count
  function automatic logic [arf_pkg::LVL_W-1:0] trig_level(input logic [1:0] sel, input logic two);
    logic [arf_pkg::LVL_W-1:0] lvl;
    lvl = arf_pkg::TL_1CH_0;
    case (sel)
      2'h0: lvl = two ? arf_pkg::TL_2CH_0 : arf_pkg::TL_1CH_0;
      2'h1: lvl = two ? arf_pkg::TL_2CH_1 : arf_pkg::TL_1CH_1;
      2'h2: lvl = two ? arf_pkg::TL_2CH_2 : arf_pkg::TL_1CH_2;
      default: lvl = two ? arf_pkg::TL_2CH_3 : arf_pkg::TL_1CH_3;
    endcase
    return lvl;
  endfunction : trig_level

  // offset binary passes, twos complement flips the sign bit
  function automatic logic [11:0] fmt_code(input logic [11:0] raw, input logic twos);
    return twos ? {~raw[arf_pkg::SIGN_BIT], raw[arf_pkg::SIGN_BIT-1:0]} : raw;
  endfunction : fmt_code

  assign pin_raw = {conversion_clock_i, chip_select_low_n_i, chip_select_high_i,
                    read_strobe_n_i, write_strobe_n_i, data_i};

  // two-stage synchroniser per pin, then a delay stage for edges
  genvar g;
  generate
    for (g = 0; g < arf_pkg::PIN_W; g++)
    begin : g_sync
      always_ff @(posedge core_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          pin_s1[g] <= 1'b1;
          pin_s2[g] <= 1'b1;
          pin_q[g] <= 1'b1;
        end
        else if (clk_en_i)
        begin
          pin_s1[g] <= pin_raw[g];
          pin_s2[g] <= pin_s1[g];
          pin_q[g] <= pin_s2[g];
        end
      end
    end
  endgenerate

  assign rd_act = !pin_s2[arf_pkg::PIN_CSL_N] && pin_s2[arf_pkg::PIN_CSH] && !pin_s2[arf_pkg::PIN_RD_N];
  assign wr_act = !pin_s2[arf_pkg::PIN_CSL_N] && pin_s2[arf_pkg::PIN_CSH] && !pin_s2[arf_pkg::PIN_WR_N];
  assign rd_start = rd_act && !rd_act_q;
  assign wr_start = wr_act && !wr_act_q;
  assign cclk_fall = !pin_s2[arf_pkg::PIN_CCLK] && pin_q[arf_pkg::PIN_CCLK];

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
    end
  end

  // control register writes
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      conversion_config <= arf_pkg::CONV_CFG_RST;
      fifo_output_config <= arf_pkg::FIFO_CFG_RST;
      fifo_clear <= 1'b0;
      soft_rst <= 1'b0;
    end
    else if (clk_en_i)
    begin
      fifo_clear <= 1'b0;
      soft_rst <= 1'b0;
      if (soft_rst)
      begin
        conversion_config <= arf_pkg::CONV_CFG_RST;
        fifo_output_config <= arf_pkg::FIFO_CFG_RST;
      end
      else if (wr_start)
      begin
        case (pin_s2[arf_pkg::ADDR_HI:arf_pkg::ADDR_LO])
          arf_pkg::ADDR_CONV_CFG: conversion_config <= pin_s2[arf_pkg::REG_W-1:0];
          arf_pkg::ADDR_FIFO_CFG:
          begin
            fifo_output_config <= pin_s2[arf_pkg::REG_W-1:0] & ~arf_pkg::FIFO_CFG_SELF_CLR;
            fifo_clear <= pin_s2[arf_pkg::FC_OVF_FRST] | pin_s2[arf_pkg::FC_SOFT_RST];
            soft_rst <= pin_s2[arf_pkg::FC_SOFT_RST];
          end
          default:
          begin
            conversion_config <= conversion_config;
          end
        endcase
      end
    end
  end

  assign two_ch = conversion_config[arf_pkg::CC_AUTOSCAN] &&
                  !conversion_config[arf_pkg::CC_BAL_LO] && !conversion_config[arf_pkg::CC_BAL_HI];
  assign trig_lvl = trig_level(fifo_output_config[arf_pkg::FC_TRIG_HI:arf_pkg::FC_TRIG_LO], two_ch);

  // conversion pipeline: falling edges start; single mode steps on the core clock
  assign conv_start = cclk_fall && !conversion_config[arf_pkg::CC_PWRDN];
  assign pipe_adv = conversion_config[arf_pkg::CC_MODE] ? 1'b1 : cclk_fall;
  assign pipe_out = pipe_v[arf_pkg::PIPE_LAT-1];

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pipe_v <= '0;
    end
    else if (clk_en_i)
    begin
      if (fifo_clear)
      begin
        pipe_v <= '0;
      end
      else if (pipe_adv)
      begin
        pipe_v <= {pipe_v[arf_pkg::PIPE_LAT-2:0], conv_start};
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (clk_en_i && pipe_adv)
    begin
      pipe_a[0] <= sample_a_i;
      pipe_b[0] <= sample_b_i;
      for (int i = 1; i < arf_pkg::PIPE_LAT; i++)
      begin
        pipe_a[i] <= pipe_a[i-1];
        pipe_b[i] <= pipe_b[i-1];
      end
    end
  end

  // channel sequencer, channel A always first
  assign cur_code = (seq == arf_pkg::SEQ_CH_B) ? hold_b : hold_a;
  assign seq_w.data = fmt_code(cur_code, fifo_output_config[arf_pkg::FC_FORMAT]);
  assign seq_w.valid = (seq != arf_pkg::SEQ_IDLE);
  assign drop = pipe_out && pipe_adv && (seq != arf_pkg::SEQ_IDLE);

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      seq <= arf_pkg::SEQ_IDLE;
      hold_a <= 12'h000;
      hold_b <= 12'h000;
      hold_two <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (fifo_clear)
      begin
        seq <= arf_pkg::SEQ_IDLE;
      end
      else
      begin
        case (seq)
          arf_pkg::SEQ_IDLE:
          begin
            if (pipe_out && pipe_adv)
            begin
              hold_a <= pipe_a[arf_pkg::PIPE_LAT-1];
              hold_b <= pipe_b[arf_pkg::PIPE_LAT-1];
              hold_two <= two_ch;
              seq <= arf_pkg::SEQ_CH_A;
            end
          end
          arf_pkg::SEQ_CH_A:
          begin
            if (seq_w.ready)
            begin
              seq <= hold_two ? arf_pkg::SEQ_CH_B : arf_pkg::SEQ_IDLE;
            end
          end
          arf_pkg::SEQ_CH_B:
          begin
            if (seq_w.ready)
            begin
              seq <= arf_pkg::SEQ_IDLE;
            end
          end
          default: seq <= arf_pkg::SEQ_IDLE;
        endcase
      end
    end
  end

  arf_word_buf u_buf (
    .clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .clk_en_i(clk_en_i),
    .clear_i(fifo_clear),
    .in_w(seq_w.snk),
    .out_w(fifo_w.src)
  );

  // circular FIFO
  assign fifo_w.ready = (level != arf_pkg::LVL_FULL);
  assign store = fifo_w.valid && fifo_w.ready;
  assign take = rd_start && !fifo_output_config[arf_pkg::FC_READBACK] && (level != '0);

  always_ff @(posedge core_clk_i)
  begin
    if (clk_en_i && store)
    begin
      fifo_mem[wr_last + arf_pkg::PTR_ONE] <= fifo_w.data;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_ptr <= '0;
      wr_last <= '1;
      level <= '0;
      new_cnt <= '0;
      data_ready_n_o <= 1'b1;
    end
    else if (clk_en_i)
    begin
      data_ready_n_o <= 1'b1;
      if (fifo_clear)
      begin
        rd_ptr <= '0;
        wr_last <= '1;
        level <= '0;
        new_cnt <= '0;
      end
      else
      begin
        if (store)
        begin
          wr_last <= wr_last + arf_pkg::PTR_ONE;
          if (new_cnt + arf_pkg::LVL_ONE >= trig_lvl)
          begin
            new_cnt <= '0;
            data_ready_n_o <= 1'b0;
          end
          else
          begin
            new_cnt <= new_cnt + arf_pkg::LVL_ONE;
          end
        end
        if (take)
        begin
          rd_ptr <= rd_ptr + arf_pkg::PTR_ONE;
        end
        level <= level + {4'h0, store} - {4'h0, take};
      end
    end
  end

  // overflow: a result dropped while the path stalled; set beats clear
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      overflow <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (drop)
      begin
        overflow <= 1'b1;
      end
      else if (fifo_clear)
      begin
        overflow <= 1'b0;
      end
    end
  end

  // host read data: FIFO word, or registers alternately when readback is on
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      data_o <= 12'h000;
      data_oe_o <= 1'b0;
      rb_sel <= 1'b0;
    end
    else if (clk_en_i)
    begin
      data_oe_o <= rd_act;
      if (rd_start)
      begin
        if (fifo_output_config[arf_pkg::FC_READBACK])
        begin
          rb_sel <= ~rb_sel;
          data_o <= rb_sel ? {arf_pkg::ADDR_FIFO_CFG, fifo_output_config | {8'h00, overflow, 1'b0}}
                           : {arf_pkg::ADDR_CONV_CFG, conversion_config};
        end
        else
        begin
          rb_sel <= 1'b0;
          data_o <= fifo_mem[rd_ptr];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      powerdown_o <= 1'b0;
      ref_select_o <= 1'b0;
      test_sel_o <= 2'h0;
    end
    else if (clk_en_i)
    begin
      powerdown_o <= conversion_config[arf_pkg::CC_PWRDN];
      ref_select_o <= conversion_config[arf_pkg::CC_REF_SEL];
      test_sel_o <= conversion_config[arf_pkg::CC_TEST_HI:arf_pkg::CC_TEST_LO];
    end
  end

  a_twos_midscale: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (seq_w.valid && cur_code == 12'h800 && fifo_output_config[arf_pkg::FC_FORMAT]) |-> seq_w.data == 12'h000)
    else $error("twos complement midscale not zero");
  a_binary_fullscale: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (seq_w.valid && cur_code == 12'hfff && !fifo_output_config[arf_pkg::FC_FORMAT]) |-> seq_w.data == 12'hfff)
    else $error("binary full scale altered");
  a_level_bound: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    level <= arf_pkg::LVL_FULL) else $error("fifo level above sixteen");
  a_store_newest: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (clk_en_i && store && !fifo_clear) |=> fifo_mem[wr_last] == $past(fifo_w.data))
    else $error("write pointer not at newest sample");
  a_read_advance: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (clk_en_i && take && !fifo_clear) |=> rd_ptr == $past(rd_ptr) + arf_pkg::PTR_ONE)
    else $error("read pointer did not advance");
  a_ready_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (clk_en_i && !data_ready_n_o) |=> data_ready_n_o) else $error("data ready held low");
  a_trig_count: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (!data_ready_n_o && $past(clk_en_i)) |-> $past(store) && $past(new_cnt) + arf_pkg::LVL_ONE >= $past(trig_lvl))
    else $error("data ready without trigger level");
  a_reserved_write: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (clk_en_i && wr_start && !soft_rst && pin_s2[arf_pkg::ADDR_HI]) |=>
    $stable(conversion_config) && $stable(fifo_output_config)) else $error("reserved write changed a register");
  a_fifo_reset: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (clk_en_i && fifo_clear) |=> level == '0 && new_cnt == '0 && rd_ptr == '0)
    else $error("buffer reset left pointers");
  a_chan_order: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (seq == arf_pkg::SEQ_CH_B) |-> $past(seq) != arf_pkg::SEQ_IDLE) else $error("channel B before channel A");
  a_read_gate: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (clk_en_i && data_oe_o) |-> $past(rd_act)) else $error("bus driven without read");

endmodule : arf_host_port
`default_nettype wire

// >>> arf_core_model.sv
// Purpose: converter core stand-in, drives samples and conversion starts
// Assumes: starts are spaced far apart
// Notes: start pin idles high between conversions
`timescale 1ns/1ps
`default_nettype none
module arf_core_model (
  // clock
  input wire logic clk_i,
  // toward the port
  output logic conversion_clock_o,
  output logic [11:0] samp_a_o,
  output logic [11:0] samp_b_o
);
  initial
  begin
    conversion_clock_o = 1'b1;
    samp_a_o = 12'h000;
    samp_b_o = 12'h000;
  end

  // samples held until the next start
  task automatic convert(input logic [11:0] a, input logic [11:0] b);
    samp_a_o = a;
    samp_b_o = b;
    conversion_clock_o = 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    conversion_clock_o = 1'b1;
    repeat (20) @(posedge clk_i);
    #1;
  endtask : convert
endmodule : arf_core_model
`default_nettype wire

// >>> arf_host_port_bench.sv
// Purpose: self-checking bench of the result fifo host port
// Assumes: single conversion mode for result timing, continuous mode in the last test only
// Notes: pins change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module arf_host_port_bench;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic csl_n = 1'b1;
  logic csh = 1'b0;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [11:0] din = 12'h000;
  logic [11:0] dout, samp_a, samp_b, got;
  logic oe, rdy_n, pd, rsel, cclk;
  logic [1:0] tsel;
  logic [11:0] codes [3] = '{12'hfff, 12'h800, 12'h000};
  logic [9:0] modes [2] = '{10'h002, 10'h022};
  int failures = 0;
  int checked = 0;
  int pulses = 0;
  int f, m, i, p;

  arf_host_port dut_u (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1),
    .sample_a_i(samp_a), .sample_b_i(samp_b), .conversion_clock_i(cclk),
    .chip_select_low_n_i(csl_n), .chip_select_high_i(csh), .read_strobe_n_i(rd_n),
    .write_strobe_n_i(wr_n), .data_i(din), .data_o(dout), .data_oe_o(oe),
    .data_ready_n_o(rdy_n), .powerdown_o(pd), .ref_select_o(rsel), .test_sel_o(tsel)
  );
  arf_core_model core_u (.clk_i(core_clk_i), .conversion_clock_o(cclk), .samp_a_o(samp_a), .samp_b_o(samp_b));

  always #5 core_clk_i = ~core_clk_i;

  // a stuck-low strobe counts once per cycle
  always @(posedge core_clk_i)
    if (rdy_n === 1'b0)
      pulses++;

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick

  task automatic print_verdict;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [11:0] act, input logic [11:0] exp);
    checked++;
    if (exp !== act)
    begin
      failures++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask : cmp

  task automatic wr(input logic [1:0] a, input logic [9:0] v);
    din = {a, v};
    csl_n = 1'b0;
    csh = 1'b1;
    wr_n = 1'b0;
    tick(4);
    wr_n = 1'b1;
    csl_n = 1'b1;
    tick(4);
  endtask : wr

  task automatic rd(output logic [11:0] d);
    int n;
    n = 0;
    csl_n = 1'b0;
    csh = 1'b1;
    rd_n = 1'b0;
    while (oe !== 1'b1 && n < 10)
    begin
      tick(1);
      n++;
    end
    if (n == 10)
    begin
      failures++;
      print_verdict();
    end
    d = dout;
    tick(3);
    rd_n = 1'b1;
    csl_n = 1'b1;
    tick(5);
  endtask : rd

  task automatic conv_chk(input logic [11:0] a, input logic [11:0] b, input int np);
    p = pulses;
    core_u.convert(a, b);
    cmp(12'(pulses - p), 12'(np));
  endtask : conv_chk

  initial
  begin
    tick(8);
    cmp({6'h00, rdy_n, oe, pd, rsel, tsel}, 12'h020);
    rst_b_i = 1'b1;
    tick(2);
    wr(2'h0, 10'h321);
    cmp({8'h00, tsel, pd, rsel}, 12'h00d);
    wr(2'h2, 10'h004);
    wr(2'h3, 10'h006);
    cmp({8'h00, tsel, pd, rsel}, 12'h00d);
    $display("test registers done");
    for (m = 0; m < 2; m++)
      for (f = 0; f < 2; f++)
      begin
        wr(2'h0, modes[m]);
        wr(2'h1, (f == 1) ? 10'h080 : 10'h000);
        for (i = 0; i < 3; i++)
        begin
          conv_chk(codes[i], 12'h000, 1);
          rd(got);
          cmp(got, (f == 1) ? codes[i] ^ 12'h800 : codes[i]);
        end
      end
    $display("test formats done");
    // high chip select inactive: no read may happen
    csh = 1'b0;
    csl_n = 1'b0;
    rd_n = 1'b0;
    tick(6);
    cmp({11'h000, oe}, 12'h000);
    rd_n = 1'b1;
    csl_n = 1'b1;
    tick(4);
    wr(2'h1, 10'h004);
    for (i = 0; i < 4; i++)
      conv_chk(12'h100 + 12'(i), 12'h000, (i == 3) ? 1 : 0);
    for (i = 0; i < 4; i++)
    begin
      rd(got);
      cmp(got, 12'h100 + 12'(i));
    end
    $display("test trigger four done");
    wr(2'h0, 10'h082);
    wr(2'h1, 10'h000);
    conv_chk(12'h123, 12'h456, 1);
    conv_chk(12'h789, 12'habc, 1);
    for (i = 0; i < 4; i++)
    begin
      rd(got);
      cmp(got, (i[0] == 1'b0) ? ((i == 0) ? 12'h123 : 12'h789) : ((i == 1) ? 12'h456 : 12'habc));
    end
    $display("test autoscan done");
    conv_chk(12'h111, 12'h222, 1);
    wr(2'h1, 10'h001);
    cmp({8'h00, tsel, pd, rsel}, 12'h000);
    wr(2'h0, 10'h006);
    conv_chk(12'h555, 12'h000, 0);
    cmp({11'h000, pd}, 12'h001);
    wr(2'h0, 10'h002);
    conv_chk(12'h333, 12'h000, 1);
    rd(got);
    cmp(got, 12'h333);
    $display("test buffer reset done");
    // readback alternates the two registers, address on the top bits
    wr(2'h1, 10'h200);
    rd(got);
    cmp(got, 12'h002);
    rd(got);
    cmp(got, 12'h600);
    $display("test readback done");
    // continuous mode: first pulse after a buffer reset needs seven extra edges
    wr(2'h0, 10'h000);
    wr(2'h1, 10'h002);
    for (i = 0; i < 8; i++)
      conv_chk(12'h400 + 12'(i), 12'h000, (i == 7) ? 1 : 0);
    rd(got);
    cmp(got, 12'h400);
    $display("test continuous done");
    print_verdict();
  end
endmodule : arf_host_port_bench
`default_nettype wire
